// File: comparator_control_regs.sv
// Purpose: control and status registers for two analog comparators
// Assumes: sfr bus on ref_clk; cmp1_raw is asynchronous; edge enables of comparator 1 come from outside
// Notes:   read data is registered and shows the addressed register one cycle later
`timescale 1ns/1ps
module comparator_control_regs #(
	parameter logic [7:0] mux_addr   = cmp_regs_pkg::mux_addr_dflt,
	parameter logic [7:0] c1ctl_addr = cmp_regs_pkg::c1ctl_addr_dflt
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// special function register bus
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// comparator 0 settings and its edge flags from its control register
	output logic      [1:0] cmp0_neg_sel,
	output logic      [1:0] cmp0_pos_sel,
	output logic      [1:0] cmp0_resp,
	input  wire logic       cmp0_rise_flag,
	input  wire logic       cmp0_fall_flag,
	output logic            cmp0_rise_irq,
	output logic            cmp0_fall_irq,
	// comparator 1 core
	input  wire logic       cmp1_raw,
	input  wire logic       cmp1_rise_irq_en,
	input  wire logic       cmp1_fall_irq_en,
	output logic            cmp1_on,
	output logic      [1:0] cmp1_pos_hyst,
	output logic      [1:0] cmp1_neg_hyst,
	output logic            cmp1_rise_irq,
	output logic            cmp1_fall_irq
);
	typedef struct packed {
		logic [1:0] nsel;
		logic [1:0] psel;
		logic       rise_en;
		logic       fall_en;
		logic [1:0] resp;
		logic       on;
		logic       rflag;
		logic       fflag;
		logic [1:0] physt;
		logic [1:0] nhyst;
		logic       s1;
		logic       s2;
		logic       prev;
		logic [7:0] rdata;
		logic       irq0r;
		logic       irq0f;
		logic       irq1r;
		logic       irq1f;
	} regs_s;

	localparam regs_s reg_reset = '{
		nsel:    cmp_regs_pkg::mux_reset[cmp_regs_pkg::neg_sel_lsb +: 2],
		psel:    cmp_regs_pkg::mux_reset[cmp_regs_pkg::pos_sel_lsb +: 2],
		rise_en: cmp_regs_pkg::mode_reset[cmp_regs_pkg::rise_en_bit],
		fall_en: cmp_regs_pkg::mode_reset[cmp_regs_pkg::fall_en_bit],
		resp:    cmp_regs_pkg::mode_reset[cmp_regs_pkg::resp_lsb +: 2],
		on:      cmp_regs_pkg::c1ctl_reset[cmp_regs_pkg::on_bit],
		rflag:   cmp_regs_pkg::c1ctl_reset[cmp_regs_pkg::rise_flg_bit],
		fflag:   cmp_regs_pkg::c1ctl_reset[cmp_regs_pkg::fall_flg_bit],
		physt:   cmp_regs_pkg::c1ctl_reset[cmp_regs_pkg::physt_lsb +: 2],
		nhyst:   cmp_regs_pkg::c1ctl_reset[cmp_regs_pkg::nhyst_lsb +: 2],
		default: '0
	};

	regs_s s_q;
	regs_s s_d;

	// address decode shared by the write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
		hit = (a == want);
	endfunction : hit

	logic wr_mux;
	logic wr_mode;
	logic wr_c1;
	logic rise_set;
	logic fall_set;
	assign wr_mux   = sfr_wr && hit(sfr_addr, mux_addr);
	assign wr_mode  = sfr_wr && hit(sfr_addr, cmp_regs_pkg::mode_addr);
	assign wr_c1    = sfr_wr && hit(sfr_addr, c1ctl_addr);
	assign rise_set = s_q.s2 && !s_q.prev;
	assign fall_set = !s_q.s2 && s_q.prev;

	// next state of every register
	always_comb begin
		s_d = s_q;
		// two-stage synchroniser, then one stage of history for edges
		s_d.s1   = cmp1_raw;
		s_d.s2   = s_q.s1;
		s_d.prev = s_q.s2;
		if (wr_mux) begin
			s_d.nsel = sfr_wdata[cmp_regs_pkg::neg_sel_lsb +: 2];
			s_d.psel = sfr_wdata[cmp_regs_pkg::pos_sel_lsb +: 2];
		end
		if (wr_mode) begin
			s_d.rise_en = sfr_wdata[cmp_regs_pkg::rise_en_bit];
			s_d.fall_en = sfr_wdata[cmp_regs_pkg::fall_en_bit];
			s_d.resp    = sfr_wdata[cmp_regs_pkg::resp_lsb +: 2];
		end
		if (wr_c1) begin
			s_d.on    = sfr_wdata[cmp_regs_pkg::on_bit];
			s_d.rflag = sfr_wdata[cmp_regs_pkg::rise_flg_bit];
			s_d.fflag = sfr_wdata[cmp_regs_pkg::fall_flg_bit];
			s_d.physt = sfr_wdata[cmp_regs_pkg::physt_lsb +: 2];
			s_d.nhyst = sfr_wdata[cmp_regs_pkg::nhyst_lsb +: 2];
		end
		// hardware set wins over a clear written in the same cycle
		if (rise_set) begin
			s_d.rflag = 1'b1;
		end
		if (fall_set) begin
			s_d.fflag = 1'b1;
		end
		// masked requests, registered so they leave straight from flops
		s_d.irq0r = cmp0_rise_flag && s_q.rise_en;
		s_d.irq0f = cmp0_fall_flag && s_q.fall_en;
		s_d.irq1r = s_q.rflag && cmp1_rise_irq_en;
		s_d.irq1f = s_q.fflag && cmp1_fall_irq_en;
		// read mux; unmapped addresses read zero
		s_d.rdata = 8'h00;
		if (hit(sfr_addr, mux_addr)) begin
			s_d.rdata = cmp_regs_pkg::mux_unused_ones;
			s_d.rdata[cmp_regs_pkg::neg_sel_lsb +: 2] = s_q.nsel;
			s_d.rdata[cmp_regs_pkg::pos_sel_lsb +: 2] = s_q.psel;
		end else if (hit(sfr_addr, cmp_regs_pkg::mode_addr)) begin
			s_d.rdata[cmp_regs_pkg::rise_en_bit]    = s_q.rise_en;
			s_d.rdata[cmp_regs_pkg::fall_en_bit]    = s_q.fall_en;
			s_d.rdata[cmp_regs_pkg::resp_lsb +: 2]  = s_q.resp;
		end else if (hit(sfr_addr, c1ctl_addr)) begin
			s_d.rdata[cmp_regs_pkg::on_bit]         = s_q.on;
			s_d.rdata[cmp_regs_pkg::out_bit]        = s_q.s2;
			s_d.rdata[cmp_regs_pkg::rise_flg_bit]   = s_q.rflag;
			s_d.rdata[cmp_regs_pkg::fall_flg_bit]   = s_q.fflag;
			s_d.rdata[cmp_regs_pkg::physt_lsb +: 2] = s_q.physt;
			s_d.rdata[cmp_regs_pkg::nhyst_lsb +: 2] = s_q.nhyst;
		end
	end

	// single state register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= reg_reset;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs come straight from state flops
	assign sfr_rdata     = s_q.rdata;
	assign cmp0_neg_sel  = s_q.nsel;
	assign cmp0_pos_sel  = s_q.psel;
	assign cmp0_resp     = s_q.resp;
	assign cmp0_rise_irq = s_q.irq0r;
	assign cmp0_fall_irq = s_q.irq0f;
	assign cmp1_on       = s_q.on;
	assign cmp1_pos_hyst = s_q.physt;
	assign cmp1_neg_hyst = s_q.nhyst;
	assign cmp1_rise_irq = s_q.irq1r;
	assign cmp1_fall_irq = s_q.irq1f;

	property p_neg_sel;
		@(posedge ref_clk) disable iff (rst) wr_mux |=> cmp0_neg_sel == $past(sfr_wdata[5:4]);
	endproperty
	a_neg_sel: assert property (p_neg_sel) else $error("negative select not stored");

	property p_pos_sel;
		@(posedge ref_clk) disable iff (rst) wr_mux |=> cmp0_pos_sel == $past(sfr_wdata[1:0]);
	endproperty
	a_pos_sel: assert property (p_pos_sel) else $error("positive select not stored");

	property p_mux_ones;
		@(posedge ref_clk) disable iff (rst)
			hit(sfr_addr, mux_addr) |=> (sfr_rdata[7:6] == 2'h3) && (sfr_rdata[3:2] == 2'h3);
	endproperty
	a_mux_ones: assert property (p_mux_ones) else $error("mux unused bits not one");

	property p_resp;
		@(posedge ref_clk) disable iff (rst) wr_mode |=> cmp0_resp == $past(sfr_wdata[1:0]);
	endproperty
	a_resp: assert property (p_resp) else $error("response mode not stored");

	property p_mode_zero;
		@(posedge ref_clk) disable iff (rst)
			hit(sfr_addr, cmp_regs_pkg::mode_addr) |=> (sfr_rdata[7:6] == 2'h0) && (sfr_rdata[3:2] == 2'h0);
	endproperty
	a_mode_zero: assert property (p_mode_zero) else $error("mode unused bits not zero");

	property p_irq_en;
		@(posedge ref_clk) disable iff (rst)
			wr_mode ##1 cmp0_rise_flag |=> cmp0_rise_irq == $past(sfr_wdata[5], 2);
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("rise enable not honoured");

	property p_on;
		@(posedge ref_clk) disable iff (rst) wr_c1 |=> cmp1_on == $past(sfr_wdata[7]);
	endproperty
	a_on: assert property (p_on) else $error("enable bit not stored");

	property p_rise;
		@(posedge ref_clk) disable iff (rst) $rose(s_q.s2) |-> (rise_set && !fall_set) ##1 s_q.rflag;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge not flagged");

	property p_fall_hold;
		@(posedge ref_clk) disable iff (rst) s_q.fflag && !(wr_c1 && !sfr_wdata[4]) |=> s_q.fflag;
	endproperty
	a_fall_hold: assert property (p_fall_hold) else $error("falling flag lost");

	property p_hyst;
		@(posedge ref_clk) disable iff (rst)
			wr_c1 |=> {cmp1_pos_hyst, cmp1_neg_hyst} == $past(sfr_wdata[3:0]);
	endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis not stored");

	property p_out_read;
		@(posedge ref_clk) disable iff (rst) hit(sfr_addr, c1ctl_addr) |=> sfr_rdata[6] == $past(s_q.s2);
	endproperty
	a_out_read: assert property (p_out_read) else $error("output state misread");

	property p_irq1;
		@(posedge ref_clk) disable iff (rst) ##1 cmp1_fall_irq == $past(s_q.fflag && cmp1_fall_irq_en);
	endproperty
	a_irq1: assert property (p_irq1) else $error("falling request wrong");

	property p_one_flag;
		@(posedge ref_clk) disable iff (rst)
			(s_q.s2 != s_q.prev) && !wr_c1 |=>
				($past(s_q.s2) ? (s_q.rflag && (s_q.fflag == $past(s_q.fflag)))
					: (s_q.fflag && (s_q.rflag == $past(s_q.rflag))));
	endproperty
	a_one_flag: assert property (p_one_flag) else $error("edge seen twice");
endmodule : comparator_control_regs

// File: cmp_regs_pkg.sv
// Purpose: constants for the comparator control register bank
// Assumes: 8-bit special function register bus, one system clock
// Notes:   addresses of the mux and comparator 1 control registers are parameters of the top
package cmp_regs_pkg;
	// register addresses
	localparam logic [7:0] mode_addr       = 8'h9d;
	localparam logic [7:0] mux_addr_dflt   = 8'h9f;
	localparam logic [7:0] c1ctl_addr_dflt = 8'h9a;
	// reset values
	localparam logic [7:0] mux_reset   = 8'hff;
	localparam logic [7:0] mode_reset  = 8'h02;
	localparam logic [7:0] c1ctl_reset = 8'h00;
	// field positions
	localparam int neg_sel_lsb  = 4;
	localparam int pos_sel_lsb  = 0;
	localparam int rise_en_bit  = 5;
	localparam int fall_en_bit  = 4;
	localparam int resp_lsb     = 0;
	localparam int on_bit       = 7;
	localparam int out_bit      = 6;
	localparam int rise_flg_bit = 5;
	localparam int fall_flg_bit = 4;
	localparam int physt_lsb    = 2;
	localparam int nhyst_lsb    = 0;
	// unused bits of the mux register read as ones
	localparam logic [7:0] mux_unused_ones = 8'hcc;
	// typical response times per mode, in ns
	localparam int resp_mode0_ns = 100;
	localparam int resp_mode1_ns = 175;
	localparam int resp_mode2_ns = 320;
	localparam int resp_mode3_ns = 1050;
	// hysteresis per code, in mV
	localparam int hyst_code1_mv = 5;
	localparam int hyst_code2_mv = 10;
	localparam int hyst_code3_mv = 20;
endpackage : cmp_regs_pkg

// File: cmp_core_model.sv
// Purpose: behavioural comparator 1 core seen from the register bank
// Assumes: bench sets the relation of the analog inputs on level
// Notes:   output moves off the clock edge, as a real asynchronous core would
`timescale 1ns/1ps
module cmp_core_model (
	// control from the register bank
	input  wire logic cmp1_on,
	// analog relation set by the bench
	input  wire logic level,
	// asynchronous comparator output
	output logic      cmp1_raw
);
	// disabled core drives low; the delay keeps edges away from ref_clk
	assign #7 cmp1_raw = cmp1_on & level;
endmodule : cmp_core_model

// File: comparator_control_regs_tb_top.sv
// Purpose: self-checking bench for the comparator register bank
// Assumes: register model kept in the bench, compared at every read
// Notes:   seed 79; comparator 1 edges come through the core model
`timescale 1ns/1ps
module comparator_control_regs_tb_top;
	logic       ref_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, level = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, got;
	logic [1:0] neg_sel, pos_sel, resp, p_hyst, n_hyst;
	logic       c0_rf = 1'b0, c0_ff = 1'b0, c1_re = 1'b0, c1_fe = 1'b0;
	logic       c0_ri, c0_fi, c1_on, cmp1_raw, c1_ri, c1_fi;
	int         mismatches = 0, n_compared = 0, seed = 79, cyc = 0, d;
	// register model written from the rules, read back at every register read
	int         mdl_mux = cmp_regs_pkg::mux_reset, mdl_mode = cmp_regs_pkg::mode_reset;
	int         mdl_ctl = cmp_regs_pkg::c1ctl_reset;

	comparator_control_regs i_comparator_control_regs (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp0_neg_sel(neg_sel),
		.cmp0_pos_sel(pos_sel), .cmp0_resp(resp), .cmp0_rise_flag(c0_rf), .cmp0_fall_flag(c0_ff),
		.cmp0_rise_irq(c0_ri), .cmp0_fall_irq(c0_fi), .cmp1_raw(cmp1_raw), .cmp1_rise_irq_en(c1_re),
		.cmp1_fall_irq_en(c1_fe), .cmp1_on(c1_on), .cmp1_pos_hyst(p_hyst), .cmp1_neg_hyst(n_hyst),
		.cmp1_rise_irq(c1_ri), .cmp1_fall_irq(c1_fi));
	cmp_core_model i_cmp_core_model (.cmp1_on(c1_on), .level(level), .cmp1_raw(cmp1_raw));

	// clock and hang guard; under two hundred cycles are expected
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one-cycle write strobe, data qualified for the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		sfr_addr  <= a;
		sfr_wr    <= 1'b1;
		sfr_wdata <= v;
		// unused bits and the read-only output bit never follow the data
		case (a)
			cmp_regs_pkg::mux_addr_dflt:   mdl_mux = v | 8'hcc;
			cmp_regs_pkg::mode_addr:       mdl_mode = v & 8'h33;
			cmp_regs_pkg::c1ctl_addr_dflt: mdl_ctl = (mdl_ctl & 8'h40) | (v & 8'hbf);
			default:                       mdl_mux = mdl_mux;
		endcase
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask : wr
	// expected read value from the bench model; unmapped reads zero
	function automatic logic [7:0] mdl_rd(input logic [7:0] a);
		case (a)
			cmp_regs_pkg::mux_addr_dflt:   mdl_rd = mdl_mux[7:0];
			cmp_regs_pkg::mode_addr:       mdl_rd = mdl_mode[7:0];
			cmp_regs_pkg::c1ctl_addr_dflt: mdl_rd = mdl_ctl[7:0];
			default:                       mdl_rd = 8'h00;
		endcase
	endfunction : mdl_rd
	// read data is registered, so sample one edge after the address lands
	task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		sfr_addr <= a;
		@(posedge ref_clk);
		#1 got = sfr_rdata;
		check(what, got, exp);
		check({what, " model"}, got, mdl_rd(a));
	endtask : chk_rd
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		wr(8'h55, 8'h00);
		chk_rd("mux reset", 8'h9f, 8'hff);
		chk_rd("mode reset", 8'h9d, 8'h02);
		chk_rd("ctl reset", 8'h9a, 8'h00);
		chk_rd("unmapped", 8'h55, 8'h00);
		check("reset outs", {neg_sel, pos_sel, resp, c1_on, p_hyst, n_hyst}, 11'h7c0);
		$display("test reset done");
		// every field code, random remaining bits and irq enables
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			d[1:0] = i[1:0];
			d[3:2] = i[1:0];
			d[5:4] = ~i[1:0];
			@(posedge ref_clk);
			c0_rf <= d[10];
			c0_ff <= d[11];
			c1_re <= d[8];
			c1_fe <= d[9];
			wr(8'h9f, d[7:0]);
			wr(8'h9d, d[7:0]);
			wr(8'h9a, d[7:0]);
			chk_rd("mux", 8'h9f, d[7:0] | 8'hcc);
			chk_rd("mode", 8'h9d, d[7:0] & 8'h33);
			chk_rd("ctl", 8'h9a, d[7:0] & 8'hbf);
			check("sel", {neg_sel, pos_sel, resp}, {d[5:4], d[1:0], d[1:0]});
			check("c1", {c1_on, p_hyst, n_hyst}, {d[7], d[3:2], d[1:0]});
			check("irq", {c0_ri, c0_fi, c1_ri, c1_fi}, {d[10] & d[5], d[11] & d[4], d[5] & d[8], d[4] & d[9]});
		end
		$display("test fields done");
		// comparator 1 edges through the synchroniser
		@(posedge ref_clk);
		c1_re <= 1'b1;
		c1_fe <= 1'b1;
		wr(8'h9a, 8'h80);
		level <= 1'b1;
		repeat (6) @(posedge ref_clk);
		mdl_ctl = mdl_ctl | 8'h60; // output high, rising flag set
		chk_rd("rise", 8'h9a, 8'he0);
		check("rise irq", {c1_ri, c1_fi}, 2'b10);
		wr(8'h9a, 8'h80);
		chk_rd("cleared", 8'h9a, 8'hc0);
		@(posedge ref_clk);
		level <= 1'b0;
		repeat (6) @(posedge ref_clk);
		mdl_ctl = (mdl_ctl & 8'hbf) | 8'h10; // output low, falling flag set
		chk_rd("fall", 8'h9a, 8'h90);
		check("fall irq", {c1_ri, c1_fi}, 2'b01);
		$display("test edges done");
		complete_run();
	end
endmodule : comparator_control_regs_tb_top
